// ### rtl/dual_bus_irq.sv
// interrupt cause, mask, select, system-error and identification logic
// assumes event inputs are synchronous one-cycle pulses on mclk_i and
// register requests come from host and bus interface logic on the same clock
`include "dual_bus_irq_map.svh"

module dual_bus_irq #(
    parameter logic [15:0] MAKER_CODE = 16'h0A5A, // arbitrary value
    parameter logic [15:0] PART_CODE  = 16'h0C3C  // arbitrary value
) (
    input  wire logic                            mclk_i,
    input  wire logic                            rst_b_i,
    input  wire logic                            single_bus_mode_i,
    input  wire logic                            decode_out_of_range_i,
    input  wire logic                            mover_out_of_range_i,
    input  wire logic                            host_out_of_range_i,
    input  wire logic [3:0]                      dma_done_i,
    input  wire logic [3:0]                      timer_expired_i,
    input  wire logic                            memory_parity_fault_i,
    input  wire dual_bus_irq_pkg::bus_events_s   bus0_events_i,
    input  wire dual_bus_irq_pkg::bus_events_s   bus1_events_i,
    input  wire dual_bus_irq_pkg::reg_req_s      req_i,
    output logic [31:0]                          rdata_o,
    output logic                                 rvalid_o,
    output logic                                 host_irq_o,
    output logic                                 bus0_irq_o,
    output logic                                 bus0_system_error_out_o,
    output logic                                 bus1_system_error_out_o
);
    logic [1:0]                rst_sync_q;
    logic                      rst_b;
    dual_bus_irq_pkg::state_s  st_q;
    dual_bus_irq_pkg::state_s  st_d;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_q[1];

    logic [31:0] ev_low;
    logic [31:0] ev_high;
    logic [31:0] low_view;
    logic [31:0] high_view;
    logic        host_sum;
    logic        bus_sum;
    logic        low_pend;
    logic        high_pend;
    logic        is_host;
    logic        wr;
    logic [7:0]  cfg_ofs;
    logic        cfg_bus1;
    logic [31:0] cause_low_n;
    logic [31:0] syserr0_ev;
    logic [31:0] syserr1_ev;

    always_comb begin
        // event vectors in cause positions
        ev_low = `RST_WORD;
        ev_low[1] = decode_out_of_range_i;
        ev_low[2] = mover_out_of_range_i;
        ev_low[3] = host_out_of_range_i;
        ev_low[7:4] = dma_done_i;
        ev_low[11:8] = timer_expired_i;
        ev_low[12] = bus0_events_i.init_read_parity;
        ev_low[13] = bus0_events_i.tgt_write_parity;
        ev_low[14] = bus0_events_i.init_write_parity;
        ev_low[15] = bus0_events_i.tgt_read_parity;
        ev_low[`POS_ADDR_PARITY] = bus0_events_i.address_parity_fault;
        ev_low[`POS_MEM_PARITY] = memory_parity_fault_i;
        ev_low[`POS_INIT_ABORT] = bus0_events_i.initiator_abort;
        ev_low[`POS_TGT_ABORT] = bus0_events_i.target_abort_seen;
        ev_low[`POS_RETRY] = bus0_events_i.retry_limit_hit;
        ev_high = `RST_WORD;
        ev_high[12] = bus1_events_i.init_read_parity;
        ev_high[13] = bus1_events_i.tgt_write_parity;
        ev_high[14] = bus1_events_i.init_write_parity;
        ev_high[15] = bus1_events_i.tgt_read_parity;
        ev_high[`POS_ADDR_PARITY] = bus1_events_i.address_parity_fault;
        ev_high[`POS_INIT_ABORT] = bus1_events_i.initiator_abort;
        ev_high[`POS_TGT_ABORT] = bus1_events_i.target_abort_seen;
        ev_high[`POS_RETRY] = bus1_events_i.retry_limit_hit;
        if (single_bus_mode_i) begin
            ev_high = `RST_WORD;
        end

        // host and bus summary bits see the low cause register only; pending bit 0 sees both cause registers
        host_sum = |(st_q.cause_low & st_q.host_mask);
        bus_sum = |(st_q.cause_low & st_q.bus0_mask);
        low_pend = |(st_q.cause_low & `MASK_ALIAS);
        high_pend = |(st_q.cause_high & `MASK_HIGH_W);
        low_view = st_q.cause_low & `MASK_ALIAS;
        low_view[0] = low_pend | high_pend;
        low_view[`POS_HOST_SUM] = host_sum;
        low_view[`POS_BUS_SUM] = bus_sum;
        high_view = single_bus_mode_i ? `RST_WORD : (st_q.cause_high & `MASK_HIGH_W);

        is_host = (req_i.src == dual_bus_irq_pkg::SRC_HOST);
        wr = req_i.valid & req_i.write & ~req_i.config_space;

        // system errors from event pulses and enables
        syserr0_ev = `RST_WORD;
        syserr0_ev[0] = bus0_events_i.address_parity_fault;
        syserr0_ev[1] = bus0_events_i.init_write_parity;
        syserr0_ev[2] = bus0_events_i.init_read_parity;
        syserr0_ev[3] = memory_parity_fault_i;
        syserr0_ev[4] = bus0_events_i.initiator_abort;
        syserr0_ev[5] = bus0_events_i.target_abort_seen;
        syserr1_ev = `RST_WORD;
        syserr1_ev[0] = bus1_events_i.address_parity_fault;
        syserr1_ev[1] = bus1_events_i.init_write_parity;
        syserr1_ev[2] = bus1_events_i.init_read_parity;
        syserr1_ev[3] = memory_parity_fault_i;
        syserr1_ev[4] = bus1_events_i.initiator_abort;
        syserr1_ev[5] = bus1_events_i.target_abort_seen;

        st_d = st_q;
        st_d.rvalid = 1'b0;
        st_d.bus0_system_error_out = |(syserr0_ev & st_q.syserr0_en);
        st_d.bus1_system_error_out = ~single_bus_mode_i & |(syserr1_ev & st_q.syserr1_en);

        // low cause: zero-write clears, doorbells follow ownership
        cause_low_n = st_q.cause_low;
        if (wr && req_i.addr == `OFS_CAUSE_LOW) begin
            cause_low_n = cause_low_n
                        & (req_i.wdata | ~`MASK_EVENTS_LOW);
            if (is_host) begin
                cause_low_n = cause_low_n | (~req_i.wdata & `MASK_HOST_DB);
                cause_low_n = cause_low_n & (req_i.wdata | ~`MASK_BUS_DB);
            end else begin
                cause_low_n = cause_low_n | (~req_i.wdata & `MASK_BUS_DB);
                cause_low_n = cause_low_n & (req_i.wdata | ~`MASK_HOST_DB);
            end
        end
        st_d.cause_low = (cause_low_n | ev_low) & `MASK_ALIAS;

        st_d.cause_high = st_q.cause_high;
        if (wr && req_i.addr == `OFS_CAUSE_HIGH && !single_bus_mode_i) begin
            st_d.cause_high = st_q.cause_high & req_i.wdata;
        end
        st_d.cause_high = (st_d.cause_high | ev_high) & `MASK_HIGH_W;

        if (wr) begin
            case (req_i.addr)
                `OFS_HOST_MASK: st_d.host_mask = req_i.wdata & `MASK_HOST_W;
                `OFS_BUS0_MASK: st_d.bus0_mask = req_i.wdata & `MASK_BUS0_W;
                `OFS_BUS0_SYSERR_EN: st_d.syserr0_en = req_i.wdata & `MASK_SYSERR_W;
                default: ;
            endcase
            if (!single_bus_mode_i) begin
                case (req_i.addr)
                    `OFS_HOST_HIGH_MASK: st_d.host_high_mask = req_i.wdata & `MASK_HIGH_W;
                    `OFS_BUS0_HIGH_MASK: st_d.bus0_high_mask = req_i.wdata & `MASK_HIGH_W;
                    `OFS_BUS1_SYSERR_EN: st_d.syserr1_en = req_i.wdata & `MASK_SYSERR_W;
                    `OFS_HOST_SELECT: st_d.host_sel = req_i.wdata[`POS_BANK_IND];
                    `OFS_BUS0_SELECT: st_d.bus0_sel = req_i.wdata[`POS_BANK_IND];
                    default: ;
                endcase
            end
        end
        if (single_bus_mode_i) begin
            st_d.host_sel = 1'b0;
            st_d.bus0_sel = 1'b0;
        end

        // read path
        cfg_ofs = req_i.addr[7:0];
        cfg_bus1 = 1'b0;
        if (req_i.config_space) begin
            case (req_i.src)
                dual_bus_irq_pkg::SRC_BUS1: cfg_bus1 = ~cfg_ofs[7];
                default: cfg_bus1 = cfg_ofs[7];
            endcase
        end
        if (req_i.valid && !req_i.write) begin
            st_d.rvalid = 1'b1;
            st_d.rdata = `RST_WORD;
            if (req_i.config_space) begin
                if ({1'b0, cfg_ofs[6:0]} == `CFG_OFS_IDENT && !(cfg_bus1 && single_bus_mode_i)) begin
                    st_d.rdata = {PART_CODE, MAKER_CODE};
                end
            end else begin
                case (req_i.addr)
                    `OFS_CAUSE_LOW: st_d.rdata = low_view;
                    `OFS_CAUSE_HIGH: st_d.rdata = high_view;
                    `OFS_HOST_MASK: st_d.rdata = st_q.host_mask;
                    `OFS_BUS0_MASK: st_d.rdata = st_q.bus0_mask;
                    `OFS_HOST_HIGH_MASK: st_d.rdata = single_bus_mode_i ? `RST_WORD : st_q.host_high_mask;
                    `OFS_BUS0_HIGH_MASK: st_d.rdata = single_bus_mode_i ? `RST_WORD : st_q.bus0_high_mask;
                    `OFS_BUS0_SYSERR_EN: st_d.rdata = st_q.syserr0_en;
                    `OFS_BUS1_SYSERR_EN: st_d.rdata = single_bus_mode_i ? `RST_WORD : st_q.syserr1_en;
                    `OFS_HOST_SELECT, `OFS_BUS0_SELECT: begin
                        st_d.rdata = ((req_i.addr == `OFS_HOST_SELECT ? st_q.host_sel : st_q.bus0_sel)
                                     ? high_view : low_view) & `MASK_ALIAS;
                        st_d.rdata[`POS_BANK_IND] = (req_i.addr == `OFS_HOST_SELECT)
                                                  ? st_q.host_sel : st_q.bus0_sel;
                        st_d.rdata[`POS_BOTH_PEND] = low_pend & high_pend;
                        if (single_bus_mode_i) begin
                            st_d.rdata = `RST_WORD;
                        end
                    end
                    default: st_d.rdata = `RST_WORD;
                endcase
            end
        end

        st_d.host_irq = |(st_d.cause_low & st_d.host_mask)
                      | |(st_d.cause_high & st_d.host_high_mask);
        st_d.bus0_irq = |(st_d.cause_low & st_d.bus0_mask)
                      | |(st_d.cause_high & st_d.bus0_high_mask);
    end

    always_ff @(posedge mclk_i or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata_o                 = st_q.rdata;
    assign rvalid_o                = st_q.rvalid;
    assign host_irq_o              = st_q.host_irq;
    assign bus0_irq_o              = st_q.bus0_irq;
    assign bus0_system_error_out_o = st_q.bus0_system_error_out;
    assign bus1_system_error_out_o = st_q.bus1_system_error_out;
endmodule

// ### rtl/dual_bus_irq_map.svh
// offsets, field positions, reset values and constants of the interrupt and config block
// assumes inclusion by bare name from the design file, the agent and the bench
`ifndef DUAL_BUS_IRQ_MAP_SVH
`define DUAL_BUS_IRQ_MAP_SVH

`define OFS_CAUSE_LOW        12'hC18
`define OFS_HOST_MASK        12'hC1C
`define OFS_BUS0_MASK        12'hC24
`define OFS_BUS0_SYSERR_EN   12'hC28
`define OFS_BUS0_SELECT      12'hC74
`define OFS_CAUSE_HIGH       12'hC98
`define OFS_HOST_HIGH_MASK   12'hC9C
`define OFS_BUS0_HIGH_MASK   12'hCA4
`define OFS_BUS1_SYSERR_EN   12'hCA8
`define OFS_HOST_SELECT      12'hC70

`define CFG_OFS_IDENT        8'h00
`define CFG_OTHER_BANK       8'h80

`define POS_ADDR_PARITY      16
`define POS_MEM_PARITY       17
`define POS_INIT_ABORT       18
`define POS_TGT_ABORT        19
`define POS_RETRY            20
`define POS_HOST_SUM         30
`define POS_BUS_SUM          31
`define POS_BANK_IND         30
`define POS_BOTH_PEND        31

`define MASK_HOST_W          32'h3C1F_FFFE
`define MASK_BUS0_W          32'h03FF_FFFE
`define MASK_HIGH_W          32'h001D_F000
`define MASK_HOST_DB         32'h03E0_0000
`define MASK_BUS_DB          32'h3C00_0000
`define MASK_EVENTS_LOW      32'h001F_FFFE
`define MASK_SYSERR_W        32'h0000_003F
`define MASK_ALIAS           32'h3FFF_FFFE

`define RST_WORD             32'h0000_0000

`endif

// ### rtl/dual_bus_irq_pkg.sv
// types shared by the interrupt aggregation and config map block
// assumes the map header sits on the include path
package dual_bus_irq_pkg;
    // who issues a register access
    typedef enum logic [1:0] {
        SRC_HOST,
        SRC_BUS0,
        SRC_BUS1
    } access_src_e;

    // per-bus event pulses
    typedef struct packed {
        logic       address_parity_fault;
        logic       init_write_parity;
        logic       init_read_parity;
        logic       tgt_write_parity;
        logic       tgt_read_parity;
        logic       initiator_abort;
        logic       target_abort_seen;
        logic       retry_limit_hit;
    } bus_events_s;

    // register access request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        config_space;
        access_src_e src;
        logic [11:0] addr;
        logic [31:0] wdata;
    } reg_req_s;

    // all state of the block except the reset synchronizer
    typedef struct packed {
        logic [31:0] cause_low;
        logic [31:0] cause_high;
        logic [31:0] host_mask;
        logic [31:0] bus0_mask;
        logic [31:0] host_high_mask;
        logic [31:0] bus0_high_mask;
        logic [31:0] syserr0_en;
        logic [31:0] syserr1_en;
        logic        host_sel;
        logic        bus0_sel;
        logic [31:0] rdata;
        logic        rvalid;
        logic        bus0_system_error_out;
        logic        bus1_system_error_out;
        logic        host_irq;
        logic        bus0_irq;
    } state_s;
endpackage

// ### verification/dual_bus_irq_agent.sv
// register access model of the host and both bus interfaces
// assumes requests are taken on the rising edge of the shared clock
`include "dual_bus_irq_map.svh"
module dual_bus_irq_agent (
    input  wire logic                 mclk_i,
    input  wire logic [31:0]          rdata_i,
    input  wire logic                 rvalid_i,
    output dual_bus_irq_pkg::reg_req_s req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] got_data;
    logic        got_valid;
    initial req_o = '0;
    // one request for one edge, then released with an inverted payload
    task automatic acc(input dual_bus_irq_pkg::access_src_e src, input logic wr,
                       input logic cfg, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        req_o <= {1'b1, wr, cfg, src, a, d};
        @(posedge mclk_i);
        req_o <= {1'b0, ~wr, ~cfg, src, ~a, ~d};
        #1;
        got_data = rdata_i;
        got_valid = rvalid_i;
    endtask
    // a zero in its own doorbell field only rings the far side
    task automatic ring(input dual_bus_irq_pkg::access_src_e src);
        if (src == dual_bus_irq_pkg::SRC_HOST) begin
            acc(src, 1'b1, 1'b0, `OFS_CAUSE_LOW, ~`MASK_HOST_DB);
        end else begin
            acc(src, 1'b1, 1'b0, `OFS_CAUSE_LOW, ~`MASK_BUS_DB);
        end
    endtask
endmodule

// ### verification/dual_bus_irq_asserts.sv
// checker for the interrupt aggregation block, bound to its top module
// assumes one clock and the active-low reset of the block
module dual_bus_irq_asserts (
    input wire logic                          mclk_i,
    input wire logic                          rst_b_i,
    input wire logic                          single_bus_mode_i,
    input wire logic                          decode_out_of_range_i,
    input wire logic                          mover_out_of_range_i,
    input wire logic                          host_out_of_range_i,
    input wire logic [3:0]                    dma_done_i,
    input wire logic [3:0]                    timer_expired_i,
    input wire logic                          memory_parity_fault_i,
    input wire dual_bus_irq_pkg::bus_events_s bus0_events_i,
    input wire dual_bus_irq_pkg::bus_events_s bus1_events_i,
    input wire dual_bus_irq_pkg::reg_req_s    req_i,
    input wire logic [31:0]                   rdata_o,
    input wire logic                          rvalid_o,
    input wire logic                          host_irq_o,
    input wire logic                          bus0_irq_o,
    input wire logic                          bus0_system_error_out_o,
    input wire logic                          bus1_system_error_out_o
);
    // events that a system-error enable can select
    function automatic logic sev(input dual_bus_irq_pkg::bus_events_s e);
        return e.address_parity_fault | e.init_write_parity | e.init_read_parity
            | e.initiator_abort | e.target_abort_seen;
    endfunction
    wire logic rd_req  = req_i.valid & ~req_i.write;
    wire logic wr_req  = req_i.valid & req_i.write;
    wire logic sev0    = sev(bus0_events_i) | memory_parity_fault_i;
    wire logic sev1    = sev(bus1_events_i) | memory_parity_fault_i;
    wire logic any_evt = decode_out_of_range_i | mover_out_of_range_i | host_out_of_range_i
        | (|dma_done_i) | (|timer_expired_i) | memory_parity_fault_i
        | (|bus0_events_i) | (|bus1_events_i);
    default clocking dclk @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    read_answer_a: assert property (rd_req |=> rvalid_o)
        else $error("read got no answer one cycle later");
    read_quiet_a: assert property (!rd_req |=> !rvalid_o)
        else $error("answer without a read");
    rdata_hold_a: assert property (!rvalid_o |-> $stable(rdata_o))
        else $error("read data moved without an answer");
    bus0_system_error_out_cause_a: assert property (bus0_system_error_out_o |-> $past(sev0))
        else $error("bus 0 system error without an event");
    bus1_system_error_out_cause_a: assert property (bus1_system_error_out_o |-> $past(sev1))
        else $error("bus 1 system error without an event");
    host_rise_a: assert property ($rose(host_irq_o) |->
        $past(any_evt | wr_req | single_bus_mode_i) || $past(single_bus_mode_i, 2))
        else $error("host interrupt rose without a cause");
    bus_rise_a: assert property ($rose(bus0_irq_o) |->
        $past(any_evt | wr_req | single_bus_mode_i) || $past(single_bus_mode_i, 2))
        else $error("bus interrupt rose without a cause");
    irq_fall_a: assert property (($fell(host_irq_o) || $fell(bus0_irq_o))
        && !single_bus_mode_i && !$past(single_bus_mode_i) |-> $past(wr_req))
        else $error("interrupt fell without a write");
    read_seen_c: cover property (rd_req ##1 rvalid_o);
    serr_only0_c: cover property (bus0_system_error_out_o && !bus1_system_error_out_o);
    irq_rise_c: cover property ($rose(host_irq_o));
endmodule

bind dual_bus_irq dual_bus_irq_asserts u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .single_bus_mode_i(single_bus_mode_i), .decode_out_of_range_i(decode_out_of_range_i),
    .mover_out_of_range_i(mover_out_of_range_i), .host_out_of_range_i(host_out_of_range_i),
    .dma_done_i(dma_done_i), .timer_expired_i(timer_expired_i),
    .memory_parity_fault_i(memory_parity_fault_i), .bus0_events_i(bus0_events_i),
    .bus1_events_i(bus1_events_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .host_irq_o(host_irq_o), .bus0_irq_o(bus0_irq_o),
    .bus0_system_error_out_o(bus0_system_error_out_o),
    .bus1_system_error_out_o(bus1_system_error_out_o));

// ### verification/dual_bus_irq_tb.sv
// self-checking bench for the interrupt aggregation and config map block
// assumes the agent model issues every register request
`include "dual_bus_irq_map.svh"
module dual_bus_irq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] IDENT = 32'h0C3C_0A5A; // arbitrary value
    localparam dual_bus_irq_pkg::access_src_e H = dual_bus_irq_pkg::SRC_HOST;
    localparam dual_bus_irq_pkg::access_src_e B0 = dual_bus_irq_pkg::SRC_BUS0;
    localparam dual_bus_irq_pkg::access_src_e B1 = dual_bus_irq_pkg::SRC_BUS1;
    logic                          mclk_i;
    logic                          rst_b_i;
    logic                          single_bus_mode_i;
    logic                          mem_fault;
    logic [10:0]                   misc;
    dual_bus_irq_pkg::bus_events_s ev;
    dual_bus_irq_pkg::reg_req_s    req;
    logic [31:0]                   rdata;
    logic                          rvalid, host_irq, bus_irq, bus0_system_error_out, bus1_system_error_out;
    int                            err_count, checked, i;
    logic [11:0] regs [11] = '{`OFS_CAUSE_LOW, `OFS_HOST_MASK, `OFS_BUS0_MASK,
        `OFS_BUS0_SYSERR_EN, `OFS_BUS0_SELECT, `OFS_CAUSE_HIGH, `OFS_HOST_HIGH_MASK,
        `OFS_BUS0_HIGH_MASK, `OFS_BUS1_SYSERR_EN, `OFS_HOST_SELECT, 12'h000};
    logic [31:0] mexp [6] = '{`MASK_HOST_W, `MASK_BUS0_W, `MASK_SYSERR_W,
        `MASK_HIGH_W, `MASK_HIGH_W, `MASK_SYSERR_W};

    dual_bus_irq #(.MAKER_CODE(16'h0A5A), .PART_CODE(16'h0C3C)) dut (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .single_bus_mode_i(single_bus_mode_i),
        .decode_out_of_range_i(misc[0]), .mover_out_of_range_i(misc[1]),
        .host_out_of_range_i(misc[2]), .dma_done_i(misc[6:3]), .timer_expired_i(misc[10:7]),
        .memory_parity_fault_i(mem_fault), .bus0_events_i(ev), .bus1_events_i(ev),
        .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .host_irq_o(host_irq),
        .bus0_irq_o(bus_irq), .bus0_system_error_out_o(bus0_system_error_out), .bus1_system_error_out_o(bus1_system_error_out));
    dual_bus_irq_agent u_agent (.mclk_i(mclk_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic rd(input dual_bus_irq_pkg::access_src_e s, input logic cfg,
                      input logic [11:0] a, input logic [31:0] exp);
        u_agent.acc(s, 1'b0, cfg, a, 32'h0);
        chk(u_agent.got_data, exp, "read data");
        chk({31'h0, u_agent.got_valid}, 32'h1, "read answer");
    endtask
    task automatic wr(input dual_bus_irq_pkg::access_src_e s, input logic [11:0] a,
                      input logic [31:0] d);
        u_agent.acc(s, 1'b1, 1'b0, a, d);
    endtask
    // e: addr, init wr, init rd, memory, abort, tgt abort, tgt wr, tgt rd, retry
    task automatic fire(input logic [8:0] e, input logic [10:0] m, input logic [1:0] exp);
        @(posedge mclk_i);
        ev <= {e[0], e[1], e[2], e[6], e[7], e[4], e[5], e[8]};
        mem_fault <= e[3];
        misc <= m;
        @(posedge mclk_i);
        ev <= '0;
        mem_fault <= 1'b0;
        misc <= '0;
        #1;
        chk({30'h0, bus1_system_error_out, bus0_system_error_out}, {30'h0, exp}, "system error");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_count++;
        conclude();
    end
    initial begin
        {rst_b_i, single_bus_mode_i, mem_fault, misc, ev, err_count, checked} = '0;
        repeat (2) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        for (i = 0; i < 11; i++) begin
            rd(H, 1'b0, regs[i], 32'h0);
        end
        rd(H, 1'b1, 12'h000, IDENT);
        rd(H, 1'b1, 12'h080, IDENT);
        rd(B0, 1'b1, 12'h000, IDENT);
        rd(B0, 1'b1, 12'h080, IDENT);
        rd(B1, 1'b1, 12'h080, IDENT);
        u_agent.acc(H, 1'b1, 1'b1, 12'h000, 32'h0);
        rd(B1, 1'b1, 12'h000, IDENT);
        for (i = 0; i < 6; i++) begin
            wr(H, regs[i < 3 ? i + 1 : i + 3], 32'hFFFF_FFFF);
            rd(H, 1'b0, regs[i < 3 ? i + 1 : i + 3], mexp[i]);
        end
        for (i = 0; i < 6; i++) begin
            wr(H, `OFS_BUS0_SYSERR_EN, 32'h1 << i);
            wr(H, `OFS_BUS1_SYSERR_EN, 32'h1 << i);
            fire(9'h1 << i, 11'h0, 2'b11);
            fire(9'h1FF & ~(9'h1 << i), 11'h0, 2'b00);
        end
        chk({30'h0, host_irq, bus_irq}, 32'h3, "irq outputs");
        rd(H, 1'b0, `OFS_CAUSE_LOW, 32'hC01F_F001);
        rd(H, 1'b0, `OFS_CAUSE_HIGH, 32'h001D_F000);
        rd(H, 1'b0, `OFS_HOST_SELECT, 32'h801F_F000);
        wr(H, `OFS_BUS0_SELECT, 32'h4000_0000);
        rd(H, 1'b0, `OFS_BUS0_SELECT, 32'hC01D_F000);
        @(posedge mclk_i);
        single_bus_mode_i <= 1'b1;
        rd(H, 1'b0, `OFS_CAUSE_HIGH, 32'h0);
        rd(H, 1'b1, 12'h080, 32'h0);
        fire(9'h020, 11'h0, 2'b01);
        @(posedge mclk_i);
        single_bus_mode_i <= 1'b0;
        fire(9'h0, 11'h7FF, 2'b00);
        rd(H, 1'b0, `OFS_CAUSE_LOW, 32'hC01F_FFFF);
        wr(H, `OFS_CAUSE_LOW, 32'hFFFF_F000);
        rd(H, 1'b0, `OFS_CAUSE_LOW, 32'hC01F_F001);
        wr(H, `OFS_HOST_MASK, 32'h0);
        wr(H, `OFS_HOST_HIGH_MASK, 32'h0);
        chk({30'h0, host_irq, bus_irq}, 32'h1, "irq outputs");
        rd(H, 1'b0, `OFS_CAUSE_LOW, 32'h801F_F001);
        wr(B0, `OFS_CAUSE_LOW, 32'h0);
        u_agent.ring(H);
        wr(H, `OFS_CAUSE_LOW, 32'h0);
        rd(H, 1'b0, `OFS_CAUSE_LOW, 32'h83E0_0001);
        wr(B1, `OFS_CAUSE_LOW, ~`MASK_HOST_DB);
        rd(H, 1'b0, `OFS_CAUSE_LOW, 32'h0000_0001);
        wr(H, `OFS_HOST_MASK, 32'hFFFF_FFFF);
        u_agent.ring(B0);
        wr(B0, `OFS_CAUSE_LOW, 32'h0);
        rd(H, 1'b0, `OFS_CAUSE_LOW, 32'h7C00_0001);
        wr(H, `OFS_CAUSE_LOW, ~`MASK_BUS_DB);
        wr(H, `OFS_CAUSE_HIGH, 32'h0);
        rd(H, 1'b0, `OFS_CAUSE_LOW, 32'h0);
        chk({30'h0, host_irq, bus_irq}, 32'h0, "irq outputs");
        conclude();
    end
endmodule
